/* File: hw/cms_pkg.sv */
// Purpose: shared constants and field layouts for the charger mask and charge-setting registers
// Assumes: 8-bit register port from the serial management engine, 50 MHz ref_clk
// Notes: current values are carried in microamps, voltages in millivolts
package cms_pkg;

  // register offsets
  localparam logic [7:0] OFS_FLAG_EXT_A = 8'h05;
  localparam logic [7:0] OFS_FLAG_FAULTS = 8'h06;
  localparam logic [7:0] OFS_MASK_EXT_A = 8'h09;
  localparam logic [7:0] OFS_MASK_FAULTS = 8'h0a;
  localparam logic [7:0] OFS_BATTERY_REG = 8'h12;
  localparam logic [7:0] OFS_FAST_CHARGE = 8'h13;
  localparam logic [7:0] OFS_PRECHARGE = 8'h14;

  // values after reset
  localparam logic [7:0] RST_MASK_EXT_A = 8'h71;
  localparam logic [7:0] RST_MASK_FAULTS = 8'h00;
  localparam logic [7:0] RST_BATTERY_REG = 8'h3c;
  localparam logic [7:0] RST_FAST_CHARGE = 8'h08;
  localparam logic [7:0] RST_PRECHARGE = 8'h02;
  localparam logic [7:0] RST_FLAGS = 8'h00;

  // bits of each register that carry a real event or mask
  localparam logic [7:0] USED_EXT_A = 8'hf1;
  localparam logic [7:0] USED_FAULTS = 8'h7f;

  // battery regulation scaling
  localparam logic [12:0] VBAT_BASE_MV = 13'h0e10;
  localparam logic [12:0] VBAT_STEP_MV = 13'h000a;
  localparam logic [6:0] VBAT_MAX_CODE = 7'h64;
  localparam logic [12:0] RST_VBAT_MV = 13'h1068;

  // charge current steps
  localparam logic [19:0] STEP_FINE_UA = 20'h004e2;
  localparam logic [19:0] STEP_COARSE_UA = 20'h009c4;
  localparam logic [19:0] RST_FAST_UA = 20'h02710;
  localparam logic [19:0] RST_PRE_UA = 20'h009c4;

  typedef struct packed {
    logic adc_ready_mask;
    logic comparator_one_alarm_mask;
    logic comparator_two_alarm_mask;
    logic comparator_three_alarm_mask;
    logic [2:0] reserved;
    logic thermistor_open_mask;
  } cms_mask_ext_a_t;

  typedef struct packed {
    logic reserved;
    logic watchdog_expiry_mask;
    logic safety_timer_expiry_mask;
    logic regulator_overcurrent_mask;
    logic current_limit_open_mask;
    logic button_wake_one_mask;
    logic button_wake_two_mask;
    logic button_reset_warning_mask;
  } cms_mask_faults_t;

  typedef struct packed {
    logic adc_ready;
    logic comparator_one_alarm;
    logic comparator_two_alarm;
    logic comparator_three_alarm;
    logic thermistor_open;
  } cms_ext_evt_t;

  typedef struct packed {
    logic watchdog_expiry;
    logic safety_timer_expiry;
    logic regulator_overcurrent;
    logic current_limit_open;
    logic button_wake_one;
    logic button_wake_two;
    logic button_reset_warning;
  } cms_fault_evt_t;

  typedef struct packed {
    logic current_step_select;
    logic [1:0] reserved;
    logic [4:0] precharge_code;
  } cms_precharge_t;

endpackage : cms_pkg

/* File: hw/cms_flag_bank.sv */
// Purpose: sticky event flags, cleared when software reads them
// Assumes: events are one-cycle pulses or levels sampled on ref_clk
// Notes: a set in the clearing cycle survives the clear
`timescale 1ns/1ps
module cms_flag_bank
  import cms_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // events and clear
  input wire logic [7:0] evt,
  input wire logic clr,
  // flag state
  output logic [7:0] flags
);

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_flag
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          flags[i] <= RST_FLAGS[i];
        end else begin
          // set wins over the read clear so no event is lost
          flags[i] <= (flags[i] & ~clr) | evt[i];
        end
      end
    end
  endgenerate

endmodule : cms_flag_bank

/* File: hw/cms_current_scale.sv */
// Purpose: converts a charge current code into microamps with the selected step
// Assumes: code width up to 8 bits
// Notes: output is registered, one cycle behind the code
`timescale 1ns/1ps
module cms_current_scale
  import cms_pkg::*;
#(
  parameter int CODE_W = 8,
  parameter logic [19:0] RST_UA = 20'h00000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // setting
  input wire logic [CODE_W-1:0] code,
  input wire logic current_step_select,
  // result
  output logic [19:0] current_ua
);

  logic [19:0] step_ua;
  logic [19:0] code_wide;

  assign step_ua = current_step_select ? STEP_COARSE_UA : STEP_FINE_UA;
  assign code_wide = {{(20 - CODE_W){1'b0}}, code};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      current_ua <= RST_UA;
    end else begin
      // max product 255 x 2500 fits in 20 bits
      current_ua <= 20'(code_wide * step_ua);
    end
  end

endmodule : cms_current_scale

/* File: hw/cms_regs.sv */
// Purpose: mask and charge-setting register slice of a linear battery charger
// Assumes: register port driven by the serial management engine, one access per strobe
// Notes: reads take one cycle; flag registers clear on read
// Function
// - The three comparator alarm mask bits (6..4 of the extended mask) suppress their interrupts when one and reset to one.
// - The ADC-ready mask in bit 7 resets to zero so conversion interrupts pass by default, and one masks it.
// - The thermistor-open mask in bit 0 resets to one, the extended mask resets to 0x71, and bits 3..1 are reserved.
// - Fault mask bits 6..3 mask watchdog, safety timer, regulator overcurrent and current-limit-open, all resetting to zero.
// - Fault mask bits 2..0 mask button wake one, wake two and reset warning when one, and bit 7 is reserved.
// - The battery target voltage is 3.6 V plus the 7-bit code times 10 mV.
// - A written code above 4.6 V saturates the setting at 4.6 V.
// - The battery regulation register resets to 0x3c, code 60, with bit 7 reserved.
// - With the step select at zero the fast-charge current is the code times 1.25 mA.
// - With the step select at one the fast-charge current is the code times 2.5 mA.
// - The fast-charge current register resets to code eight.
// - Bit 7 of the pre-charge register picks 1.25 mA or 2.5 mA charge current steps.
// - The 5-bit pre-charge code times the selected step gives the pre-charge current.
// - The pre-charge register resets to code two, step select zero and reserved bits zero.
// - The watchdog flag sets on watchdog expiry and clears when software reads its flag register.
`timescale 1ns/1ps
module cms_regs
  import cms_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // charger events
  input wire cms_ext_evt_t ext_evt,
  input wire cms_fault_evt_t fault_evt,
  // interrupt
  output logic charger_int_n,
  // charger settings
  output logic [12:0] vbat_target_mv,
  output logic [19:0] fast_charge_ua,
  output logic [19:0] precharge_ua,
  output logic current_step_select
);

  cms_mask_ext_a_t mask_ext_a;
  cms_mask_faults_t mask_faults;
  logic [7:0] battery_regulation_voltage;
  logic [7:0] fast_charge_current;
  cms_precharge_t precharge_current_control;

  logic [7:0] flags_ext_a;
  logic [7:0] flags_faults;
  logic [7:0] evt_ext_a;
  logic [7:0] evt_faults;
  logic clr_ext_a;
  logic clr_faults;

  logic wr_mask_ext_a;
  logic wr_mask_faults;
  logic wr_battery;
  logic wr_fast;
  logic wr_precharge;

  logic [6:0] next_vbat_code;
  logic [7:0] next_rdata;
  logic [7:0] pending_ext_a;
  logic [7:0] pending_faults;
  logic next_int_n;

  // address decode
  assign wr_mask_ext_a = reg_wr && (reg_addr == OFS_MASK_EXT_A);
  assign wr_mask_faults = reg_wr && (reg_addr == OFS_MASK_FAULTS);
  assign wr_battery = reg_wr && (reg_addr == OFS_BATTERY_REG);
  assign wr_fast = reg_wr && (reg_addr == OFS_FAST_CHARGE);
  assign wr_precharge = reg_wr && (reg_addr == OFS_PRECHARGE);
  assign clr_ext_a = reg_rd && (reg_addr == OFS_FLAG_EXT_A);
  assign clr_faults = reg_rd && (reg_addr == OFS_FLAG_FAULTS);

  // event placement follows the mask bit positions
  assign evt_ext_a = {ext_evt.adc_ready, ext_evt.comparator_one_alarm, ext_evt.comparator_two_alarm,
                      ext_evt.comparator_three_alarm, 3'h0, ext_evt.thermistor_open};
  assign evt_faults = {1'b0, fault_evt.watchdog_expiry, fault_evt.safety_timer_expiry,
                       fault_evt.regulator_overcurrent, fault_evt.current_limit_open,
                       fault_evt.button_wake_one, fault_evt.button_wake_two,
                       fault_evt.button_reset_warning};

  cms_flag_bank u_flags_ext_a (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .evt(evt_ext_a),
    .clr(clr_ext_a),
    .flags(flags_ext_a)
  );

  cms_flag_bank u_flags_faults (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .evt(evt_faults),
    .clr(clr_faults),
    .flags(flags_faults)
  );

  // extended mask register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_ext_a <= RST_MASK_EXT_A;
    end else if (wr_mask_ext_a) begin
      // reserved bits are read/write storage with no effect
      mask_ext_a <= reg_wdata;
    end
  end

  // fault mask register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_faults <= RST_MASK_FAULTS;
    end else if (wr_mask_faults) begin
      mask_faults <= reg_wdata;
    end
  end

  // codes above the 4.6 V ceiling are clamped on the way in
  always_comb begin
    next_vbat_code = reg_wdata[6:0];
    if (reg_wdata[6:0] > VBAT_MAX_CODE) begin
      next_vbat_code = VBAT_MAX_CODE;
    end
  end

  // battery regulation register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      battery_regulation_voltage <= RST_BATTERY_REG;
    end else if (wr_battery) begin
      battery_regulation_voltage <= {reg_wdata[7], next_vbat_code};
    end
  end

  // fast-charge current register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_charge_current <= RST_FAST_CHARGE;
    end else if (wr_fast) begin
      fast_charge_current <= reg_wdata;
    end
  end

  // pre-charge control register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      precharge_current_control <= RST_PRECHARGE;
    end else if (wr_precharge) begin
      precharge_current_control <= reg_wdata;
    end
  end

  // battery target voltage in millivolts
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vbat_target_mv <= RST_VBAT_MV;
    end else begin
      vbat_target_mv <= 13'(VBAT_BASE_MV + 13'(battery_regulation_voltage[6:0]) * VBAT_STEP_MV);
    end
  end

  // both currents share one step select, so the host sets it first
  cms_current_scale #(
    .CODE_W(8),
    .RST_UA(RST_FAST_UA)
  ) u_fast_scale (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .code(fast_charge_current),
    .current_step_select(precharge_current_control.current_step_select),
    .current_ua(fast_charge_ua)
  );

  cms_current_scale #(
    .CODE_W(5),
    .RST_UA(RST_PRE_UA)
  ) u_pre_scale (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .code(precharge_current_control.precharge_code),
    .current_step_select(precharge_current_control.current_step_select),
    .current_ua(precharge_ua)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      current_step_select <= RST_PRECHARGE[7];
    end else begin
      current_step_select <= precharge_current_control.current_step_select;
    end
  end

  // interrupt: flags always record, masks only gate the output
  assign pending_ext_a = flags_ext_a & ~mask_ext_a & USED_EXT_A;
  assign pending_faults = flags_faults & ~mask_faults & USED_FAULTS;
  assign next_int_n = ~(|pending_ext_a | |pending_faults);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      charger_int_n <= 1'b1;
    end else begin
      charger_int_n <= next_int_n;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr)
      OFS_FLAG_EXT_A: begin
        next_rdata = flags_ext_a;
      end
      OFS_FLAG_FAULTS: begin
        next_rdata = flags_faults;
      end
      OFS_MASK_EXT_A: begin
        next_rdata = mask_ext_a;
      end
      OFS_MASK_FAULTS: begin
        next_rdata = mask_faults;
      end
      OFS_BATTERY_REG: begin
        next_rdata = battery_regulation_voltage;
      end
      OFS_FAST_CHARGE: begin
        next_rdata = fast_charge_current;
      end
      OFS_PRECHARGE: begin
        next_rdata = precharge_current_control;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

endmodule : cms_regs

/* File: sim/cms_regs_asserts.sv */
// Purpose: port-level checker for the mask and charge-setting register slice
// Assumes: single ref_clk domain, asynchronous active-low rst_n
// Notes: derived outputs and the interrupt lag their cause by two edges
`timescale 1ns/1ps
module cms_regs_asserts
  import cms_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // events and interrupt
  input wire cms_ext_evt_t ext_evt,
  input wire cms_fault_evt_t fault_evt,
  input wire logic charger_int_n,
  // settings
  input wire logic [12:0] vbat_target_mv,
  input wire logic [19:0] fast_charge_ua,
  input wire logic [19:0] precharge_ua,
  input wire logic current_step_select
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_rd_ans; reg_rd |=> reg_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered next cycle");
  property p_rd_idle; !reg_rd |=> !reg_rvalid; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rvalid without read");
  property p_unmapped;
    reg_rd && !(reg_addr inside {8'h05, 8'h06, 8'h09, 8'h0a, 8'h12, 8'h13, 8'h14}) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // written values are recovered with $past so no sequence-local variables are needed
  property p_vbat;
    reg_wr && reg_addr == 8'h12 |->
      ##2 vbat_target_mv == 13'h0e10 + 13'h00a *
        (($past(reg_wdata[6:0], 2) > 7'h64) ? 7'h64 : $past(reg_wdata[6:0], 2));
  endproperty
  a_vbat: assert property (p_vbat) else $error("battery target wrong");
  property p_fast;
    reg_wr && reg_addr == 8'h13 |->
      ##2 fast_charge_ua == $past(reg_wdata, 2) * (current_step_select ? 20'h009c4 : 20'h004e2);
  endproperty
  a_fast: assert property (p_fast) else $error("fast charge current wrong");
  property p_pre;
    reg_wr && reg_addr == 8'h14 |->
      ##2 current_step_select == $past(reg_wdata[7], 2)
        && precharge_ua == $past(reg_wdata[4:0], 2) * ($past(reg_wdata[7], 2) ? 20'h009c4 : 20'h004e2);
  endproperty
  a_pre: assert property (p_pre) else $error("precharge current wrong");
  property p_int_fall;
    $fell(charger_int_n) |-> $past(ext_evt, 2) != '0 || $past(fault_evt, 2) != '0 || $past(reg_wr, 2);
  endproperty
  a_int_fall: assert property (p_int_fall) else $error("interrupt without cause");
  property p_int_rise; $rose(charger_int_n) |-> $past(reg_rvalid) || $past(reg_wr, 2); endproperty
  a_int_rise: assert property (p_int_rise) else $error("interrupt released without read");
  property p_rst;
    $rose(rst_n) |-> charger_int_n && !reg_rvalid && !current_step_select && vbat_target_mv == 13'h1068
      && fast_charge_ua == 20'h02710 && precharge_ua == 20'h009c4;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not at reset value");
  c_read: cover property (reg_rd ##1 reg_rvalid);
  c_int: cover property ($fell(charger_int_n));
  c_clamp: cover property (reg_wr && reg_addr == 8'h12 && reg_wdata[6:0] > 7'h64);
endmodule : cms_regs_asserts

bind cms_regs cms_regs_asserts cms_regs_asserts_i (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .reg_rvalid, .ext_evt, .fault_evt, .charger_int_n, .vbat_target_mv,
  .fast_charge_ua, .precharge_ua, .current_step_select);

/* File: sim/cms_host.sv */
// Purpose: host model issuing single-byte register accesses
// Assumes: callers sit just after a clock edge
// Notes: released address shows the inverse of the last value, and so does write data after a write
`timescale 1ns/1ps
module cms_host (
  // clock
  input wire logic ref_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    ok = reg_rvalid;
  endtask : rd
endmodule : cms_host

/* File: sim/cms_regs_tb.sv */
// Purpose: self-checking bench for the mask and charge-setting registers
// Assumes: host model drives the register port, bench drives the events
// Notes: a shadow map predicts every readback and derived output
`timescale 1ns/1ps
module cms_regs_tb;
  import cms_pkg::*;
  logic ref_clk, rst_n, reg_wr, reg_rd, reg_rvalid, charger_int_n, current_step_select;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  cms_ext_evt_t ext_evt;
  cms_fault_evt_t fault_evt;
  logic [12:0] vbat_target_mv;
  logic [19:0] fast_charge_ua, precharge_ua;
  int miscompares, compares;
  logic [7:0] sh[int];
  cms_host cms_host_i (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid);
  cms_regs cms_regs_i (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
    .ext_evt, .fault_evt, .charger_int_n, .vbat_target_mv, .fast_charge_ua, .precharge_ua, .current_step_select);
  task automatic test_done();
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic cmp(input string n, input logic [19:0] x, input logic [19:0] g);
    compares++;
    if (g !== x) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask : cmp
  task automatic init();
    sh = '{5: 8'h00, 6: 8'h00, 9: 8'h71, 10: 8'h00, 18: 8'h3c, 19: 8'h08, 20: 8'h02};
  endtask : init
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    cms_host_i.wr(a, v);
    if (a == 8'h12) sh[18] = {v[7], (v[6:0] > 7'h64) ? 7'h64 : v[6:0]};
    else if (a inside {8'h09, 8'h0a, 8'h13, 8'h14}) sh[a] = v;
  endtask : wr
  task automatic rchk(input logic [7:0] a);
    logic [7:0] v;
    logic ok;
    cms_host_i.rd(a, v, ok);
    cmp("rvalid", 20'h1, 20'(ok));
    cmp("rdata", 20'(sh.exists(a) ? sh[a] : 8'h00), 20'(v));
    if (a inside {8'h05, 8'h06}) sh[a] = 8'h00;
  endtask : rchk
  task automatic chk();
    repeat (3) @(posedge ref_clk);
    #1;
    cmp("int_n", 20'(~|((sh[5] & ~sh[9] & 8'hf1) | (sh[6] & ~sh[10] & 8'h7f))), 20'(charger_int_n));
    cmp("vbat", 13'h0e10 + 13'h00a * sh[18][6:0], 20'(vbat_target_mv));
    cmp("fast", 20'(sh[19]) * (sh[20][7] ? 20'h009c4 : 20'h004e2), fast_charge_ua);
    cmp("pre", 20'(sh[20][4:0]) * (sh[20][7] ? 20'h009c4 : 20'h004e2), precharge_ua);
    cmp("step", 20'(sh[20][7]), 20'(current_step_select));
    foreach (sh[k]) rchk(8'(k));
  endtask : chk
  task automatic evt(input int i);
    @(posedge ref_clk);
    #1;
    {ext_evt, fault_evt} = 12'h001 << i;
    @(posedge ref_clk);
    #1;
    {ext_evt, fault_evt} = 12'h000;
    if (i < 7) sh[6][i] = 1'b1;
    else if (i == 7) sh[5][0] = 1'b1;
    else sh[5][i - 4] = 1'b1;
  endtask : evt
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    {ext_evt, fault_evt} = 12'h000;
    miscompares = 0;
    compares = 0;
    void'($urandom(32'h486bb2d9));
    init();
    repeat (12) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    chk();
    for (int i = 0; i < 4; i++) begin
      wr(8'h09, 8'($urandom));
      wr(8'h0a, 8'($urandom));
      wr(8'h05, 8'hff);
      rchk(8'($urandom));
      chk();
    end
    foreach (sh[k]) if (k == 18) begin
      wr(8'h12, 8'h00); chk();
      wr(8'h12, 8'h64); chk();
      wr(8'h12, 8'h65); chk();
      wr(8'h12, 8'($urandom)); chk();
    end
    for (int s = 0; s < 2; s++) begin
      wr(8'h14, {s[0], 7'($urandom)});
      wr(8'h13, 8'($urandom)); chk();
      wr(8'h13, 8'hff); chk();
    end
    for (int i = 0; i < 12; i++) begin
      wr(8'h09, 8'($urandom));
      wr(8'h0a, 8'($urandom));
      evt(i); chk();
    end
    evt(6);
    @(posedge ref_clk);
    #1 rst_n = 1'b0;
    init();
    repeat (2) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    chk();
    test_done();
  end
endmodule : cms_regs_tb
